// ### design/sdw_top.sv
// Top of the serial DAC word loader: decode, control and output logic.
//
// Function
// - Shift data on falling clock while framed
// - Select bits come from word bits 13, 14
// - Select decodes system, channel or data
// - System control ignores address, hits all
// - System word carries four bits 6..3
// - Channel word carries address, reference, standby, clear
// - Channel write touches only addressed channel
// - Quad variant ignores address bit 2
// - Bit 15 picks main or fine data
// - Main ten bits, fine eight bits
// - Main write loads bits 9..0
// - Fine write loads bits 9..2
// - Load strobe copies all data to outputs except main data under software or channel clear, and nothing under hardware clear
// - Hardware clear resets data and outputs
// - Cleared main output sits at clear code
// - Cleared fine converter gives zero offset
// - Software clears leave fine data alone
// - Lowest main code depends on coding
// - Power, coding, standby and clear system bits
// - Channel clear needs load, standby acts without it
// - Reference select chooses bias source
// - Software clear sets main to clear code
module sdw_top #(
   parameter bit OCTAL_VARIANT = 1'b1
) (
   // Clock and reset.
   input  wire logic                         ref_clk,
   input  wire logic                         resetn,
   // Serial link.
   input  wire logic                         frame_sync_n,
   input  wire logic                         serial_shift_clock,
   input  wire logic                         serial_data_in,
   // Strobes.
   input  wire logic                         load_outputs_n,
   input  wire logic                         clear_request_n,
   // Converter codes.
   output logic [sdw_pkg::NUM_CH-1:0][9:0]   main_code,
   output logic [sdw_pkg::NUM_CH-1:0][7:0]   fine_code,
   // Converter control.
   output logic [sdw_pkg::NUM_CH-1:0][1:0]   reference_select,
   output logic [sdw_pkg::NUM_CH-1:0]        channel_active,
   output logic                              reference_on,
   output logic                              coding_select
);

   // ----------------------------------------
   // Strobe synchronisers
   // ----------------------------------------

   logic [1:0] ld_q;
   logic [1:0] hc_q;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ld_q <= 2'h3;
         hc_q <= 2'h3;
      end else begin
         ld_q <= {ld_q[0], load_outputs_n};
         hc_q <= {hc_q[0], clear_request_n};
      end
   end

   wire load   = ~ld_q[1];
   wire hw_clr = ~hc_q[1];

   // ----------------------------------------
   // Serial receiver
   // ----------------------------------------

   sdw_word_if word_if ();

   // Words arrive most significant bit first.
   sdw_rx u_rx (
      .ref_clk            (ref_clk),
      .resetn             (resetn),
      .frame_sync_n       (frame_sync_n),
      .serial_shift_clock (serial_shift_clock),
      .serial_data_in     (serial_data_in),
      .wout               (word_if.src)
   );

   // ----------------------------------------
   // Word decode
   // ----------------------------------------

   wire [sdw_pkg::WORD_W-1:0] w      = word_if.word;
   wire                       wvalid = word_if.valid;
   wire sdw_pkg::sdw_target_t tgt    = sdw_pkg::target_of(w);

   wire [sdw_pkg::CH_W-1:0] ch_raw = w[sdw_pkg::ADDR_HI:sdw_pkg::ADDR_LO];
   wire                     a2_use = OCTAL_VARIANT & w[sdw_pkg::BIT_ADDR2];
   wire [sdw_pkg::CH_W-1:0] ch_sel = {a2_use, ch_raw[1:0]};

   wire wr_sys   = wvalid & (tgt == sdw_pkg::TGT_SYS);
   wire wr_chan  = wvalid & (tgt == sdw_pkg::TGT_CHAN);
   wire wr_data  = wvalid & (tgt == sdw_pkg::TGT_DATA);
   wire main_sel = ~w[sdw_pkg::BIT_MAIN_SUB];

   wire [sdw_pkg::MAIN_W-1:0] main_field =
      w[sdw_pkg::MAIN_HI:sdw_pkg::MAIN_LO];
   wire [sdw_pkg::FINE_W-1:0] fine_field =
      w[sdw_pkg::FINE_HI:sdw_pkg::FINE_LO];

   // ----------------------------------------
   // Global control register
   // ----------------------------------------

   logic coding_q;
   logic pwr_n_q;
   logic astby_q;
   logic aclr_q;

   // The address field is not looked at: settings apply to all channels.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         coding_q <= sdw_pkg::CODING_RST;
         pwr_n_q  <= sdw_pkg::PWR_N_RST;
         astby_q  <= sdw_pkg::ASTBY_RST;
         aclr_q   <= sdw_pkg::ACLR_RST;
      end else if (wr_sys) begin
         coding_q <= w[sdw_pkg::BIT_CODING];
         pwr_n_q  <= w[sdw_pkg::BIT_PWR_N];
         astby_q  <= w[sdw_pkg::BIT_ASTBY];
         aclr_q   <= w[sdw_pkg::BIT_ACLR];
      end
   end

   // ----------------------------------------
   // Per-channel control registers
   // ----------------------------------------

   logic [sdw_pkg::NUM_CH-1:0][1:0] ref_sel_q;
   logic [sdw_pkg::NUM_CH-1:0]      cstby_n_q;
   logic [sdw_pkg::NUM_CH-1:0]      cclr_q;
   logic [sdw_pkg::NUM_CH-1:0]      active_q;
   logic                            ref_on_q;

   wire [1:0] ref_field =
      w[sdw_pkg::BIT_REF_HI:sdw_pkg::BIT_REF_LO];

   for (genvar i = 0; i < sdw_pkg::NUM_CH; i++) begin : g_ch
      wire hit = wr_chan & (ch_sel == i);

      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            ref_sel_q[i] <= sdw_pkg::REF_RST;
            cstby_n_q[i] <= sdw_pkg::CSTBY_N_RST;
            cclr_q[i]    <= sdw_pkg::CCLR_RST;
         end else if (hit) begin
            ref_sel_q[i] <= ref_field;
            cstby_n_q[i] <= w[sdw_pkg::BIT_CSTBY_N];
            cclr_q[i]    <= w[sdw_pkg::BIT_CCLR];
         end
      end

      // A channel runs only when neither it nor the whole part idles.
      always_ff @(posedge ref_clk) begin
         if (!resetn) begin
            active_q[i] <= 1'b0;
         end else begin
            active_q[i] <= pwr_n_q & ~astby_q & cstby_n_q[i];
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ref_on_q <= 1'b0;
      end else begin
         ref_on_q <= pwr_n_q;
      end
   end

   // ----------------------------------------
   // Data register bank
   // ----------------------------------------

   sdw_bank_if bank_if ();

   assign bank_if.wr_main   = wr_data & main_sel;
   assign bank_if.wr_fine   = wr_data & ~main_sel;
   assign bank_if.ch        = ch_sel;
   assign bank_if.main_data = main_field;
   assign bank_if.fine_data = fine_field;
   // The strobe level is used directly, so a frame in flight never delays it.
   assign bank_if.load      = load;
   assign bank_if.hw_clr    = hw_clr;
   assign bank_if.sw_clr    = aclr_q;
   assign bank_if.ch_clr    = cclr_q;
   assign bank_if.coding    = coding_q;

   sdw_bank u_bank (
      .ref_clk (ref_clk),
      .resetn  (resetn),
      .b       (bank_if.bank)
   );

   // ----------------------------------------
   // Outputs
   // ----------------------------------------

   assign main_code        = bank_if.main_out;
   assign fine_code        = bank_if.fine_out;
   assign reference_select = ref_sel_q;
   assign channel_active   = active_q;
   assign reference_on     = ref_on_q;
   assign coding_select    = coding_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);

   a_sel_data_decode: assert property (
      wvalid && w[sdw_pkg::BIT_SEL_HI] |-> wr_data && !wr_sys && !wr_chan)
      else $error("high select bit did not pick the data registers");

   a_sel_chan_decode: assert property (
      wvalid && !w[sdw_pkg::BIT_SEL_HI] && w[sdw_pkg::BIT_SEL_LO]
      |-> wr_chan && !wr_data)
      else $error("select 01 did not pick channel control");

   a_sys_write_fields: assert property (
      wr_sys |=> {coding_q, pwr_n_q, astby_q, aclr_q} ==
                 $past(w[sdw_pkg::BIT_CODING:sdw_pkg::BIT_ACLR]))
      else $error("system control bits not stored");

   a_sys_keeps_chans: assert property (
      wr_sys |=> $stable(ref_sel_q) && $stable(cstby_n_q))
      else $error("system write changed a channel register");

   a_quad_addr_mask: assert property (
      !OCTAL_VARIANT && wr_chan
      |=> ref_sel_q[$past(ch_raw[1:0])] == $past(ref_field))
      else $error("quad variant decoded address bit 2");

   a_main_write_lands: assert property (
      bank_if.wr_main && !hw_clr && !aclr_q && !(load && cclr_q[ch_sel])
      |=> bank_if.main_dat[$past(ch_sel)] == $past(main_field))
      else $error("main data write lost");

   a_fine_write_lands: assert property (
      bank_if.wr_fine && !hw_clr
      |=> bank_if.fine_dat[$past(ch_sel)] == $past(fine_field))
      else $error("fine data write lost");

   a_load_after_word: assert property (
      bank_if.wr_main && !aclr_q && !cclr_q[ch_sel] && !hw_clr
      ##1 (load && !hw_clr && !aclr_q) [*2]
      |=> main_code[$past(ch_sel, 3)] == $past(main_field, 3))
      else $error("loaded output does not show written code");

   a_sys_ctl_gated: assert property (
      !wr_sys |=> $stable({coding_q, pwr_n_q, astby_q, aclr_q}))
      else $error("system control changed without a system word");

   a_data_keeps_ctl: assert property (
      wr_data |=> $stable(ref_sel_q) && $stable(cclr_q)
                  && $stable(cstby_n_q))
      else $error("data word changed a channel control register");

   a_main_keeps_fine: assert property (
      bank_if.wr_main && !hw_clr |=> $stable(bank_if.fine_dat))
      else $error("main data write changed fine data");

   a_fine_keeps_main: assert property (
      bank_if.wr_fine && !hw_clr && !aclr_q && !load
      |=> $stable(bank_if.main_dat))
      else $error("fine data write changed main data");

   for (genvar i = 0; i < sdw_pkg::NUM_CH; i++) begin : g_chk

      a_chan_write_only: assert property (
         wr_chan && ch_sel != i
         |=> $stable(ref_sel_q[i]) && $stable(cstby_n_q[i])
             && $stable(cclr_q[i]))
         else $error("channel write hit an unaddressed channel");

      a_chan_write_fields: assert property (
         wr_chan && ch_sel == i
         |=> ref_sel_q[i] == $past(ref_field)
             && cstby_n_q[i] == $past(w[sdw_pkg::BIT_CSTBY_N])
             && cclr_q[i] == $past(w[sdw_pkg::BIT_CCLR]))
         else $error("channel control fields not stored");

      a_load_copies_data: assert property (
         load && !hw_clr && !aclr_q && !cclr_q[i]
         |=> main_code[i] == $past(bank_if.main_dat[i])
             && fine_code[i] == $past(bank_if.fine_dat[i]))
         else $error("load did not copy data to outputs");

      a_hw_clear_codes: assert property (
         hw_clr |=> main_code[i] == sdw_pkg::MAIN_CLR
                    && bank_if.main_dat[i] == sdw_pkg::MAIN_CLR
                    && fine_code[i] == sdw_pkg::fine_zero($past(coding_q)))
         else $error("hardware clear left a code behind");

      a_hw_clear_floor: assert property (
         hw_clr && coding_q
         |=> main_code[i] == sdw_pkg::MAIN_LOW_OB
             && main_code[i] != sdw_pkg::MAIN_LOW_TC)
         else $error("offset binary clear is not the lowest code");

      a_sw_clear_fine: assert property (
         aclr_q && !hw_clr && !bank_if.wr_fine
         |=> $stable(bank_if.fine_dat[i])
             && main_code[i] == sdw_pkg::MAIN_CLR)
         else $error("software clear disturbed fine data");

      a_chan_clear_load: assert property (
         load && cclr_q[i] && !hw_clr
         |=> main_code[i] == sdw_pkg::MAIN_CLR
             && ($stable(bank_if.fine_dat[i]) || $past(bank_if.wr_fine)))
         else $error("channel clear on load misbehaved");

      a_standby_follows: assert property (
         !pwr_n_q || astby_q || !cstby_n_q[i] |=> !channel_active[i])
         else $error("idle channel shown as active");

      a_active_restores: assert property (
         pwr_n_q && !astby_q && cstby_n_q[i] |=> channel_active[i])
         else $error("running channel shown as idle");

      a_sw_clear_main: assert property (
         aclr_q && !hw_clr |=> bank_if.main_dat[i] == sdw_pkg::MAIN_CLR)
         else $error("software clear left main data behind");

      a_fine_write_only: assert property (
         bank_if.wr_fine && ch_sel != i && !hw_clr
         |=> $stable(bank_if.fine_dat[i]))
         else $error("fine write hit an unaddressed channel");

      a_ref_select_kept: assert property (
         !(wr_chan && ch_sel == i) |=> $stable(ref_sel_q[i]))
         else $error("reference select changed without its write");
   end

endmodule // sdw_top

// ### design/sdw_pkg.sv
// Package: constants, types and helpers of the serial DAC word loader.
package sdw_pkg;
   localparam int NUM_CH = 8;
   localparam int CH_W   = 3;
   localparam int WORD_W = 16;
   localparam int MAIN_W = 10;
   localparam int FINE_W = 8;
   localparam int CNT_W  = 5;
   localparam logic [CNT_W-1:0] CNT_LAST = 5'h0f;
   localparam logic [CNT_W-1:0] CNT_WORD = 5'h10;
   // Word field positions.
   localparam int BIT_MAIN_SUB = 15;
   localparam int BIT_SEL_LO   = 14;
   localparam int BIT_SEL_HI   = 13;
   localparam int ADDR_HI      = 12;
   localparam int ADDR_LO      = 10;
   localparam int BIT_ADDR2    = 12;
   localparam int BIT_REF_HI   = 9;
   localparam int BIT_REF_LO   = 8;
   localparam int BIT_CODING   = 6;
   localparam int BIT_PWR_N    = 5;
   localparam int BIT_ASTBY    = 4;
   localparam int BIT_ACLR     = 3;
   localparam int BIT_CSTBY_N  = 4;
   localparam int BIT_CCLR     = 3;
   localparam int MAIN_HI      = 9;
   localparam int MAIN_LO      = 0;
   localparam int FINE_HI      = 9;
   localparam int FINE_LO      = 2;
   // Codes.
   localparam logic [MAIN_W-1:0] MAIN_CLR     = 10'h000;
   localparam logic [MAIN_W-1:0] MAIN_LOW_OB  = 10'h000;
   localparam logic [MAIN_W-1:0] MAIN_LOW_TC  = 10'h200;
   localparam logic [FINE_W-1:0] FINE_ZERO_OB = 8'h80;
   localparam logic [FINE_W-1:0] FINE_ZERO_TC = 8'h00;
   // Reset values of the control registers.
   localparam logic       CODING_RST  = 1'h0;
   localparam logic       PWR_N_RST   = 1'h1;
   localparam logic       ASTBY_RST   = 1'h0;
   localparam logic       ACLR_RST    = 1'h0;
   localparam logic [1:0] REF_RST     = 2'h0;
   localparam logic       CSTBY_N_RST = 1'h1;
   localparam logic       CCLR_RST    = 1'h0;

   typedef enum logic [1:0] {
      TGT_SYS  = 2'b00,
      TGT_CHAN = 2'b01,
      TGT_DATA = 2'b10
   } sdw_target_t;

   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_SHIFT = 2'b01,
      RX_HOLD  = 2'b10
   } sdw_rx_state_t;

   function automatic sdw_target_t target_of(logic [WORD_W-1:0] w);
      if (w[BIT_SEL_HI]) return TGT_DATA;
      else if (w[BIT_SEL_LO]) return TGT_CHAN;
      else return TGT_SYS;
   endfunction

   function automatic logic [FINE_W-1:0] fine_zero(logic coding);
      return coding ? FINE_ZERO_OB : FINE_ZERO_TC;
   endfunction
endpackage

// ### design/sdw_if.sv
// Interfaces: received words and the data register bank port.
interface sdw_word_if;
   logic                       valid;
   logic [sdw_pkg::WORD_W-1:0] word;
   modport src (output valid, output word);
   modport dst (input valid, input word);
endinterface

interface sdw_bank_if;
   logic                                           wr_main;
   logic                                           wr_fine;
   logic [sdw_pkg::CH_W-1:0]                       ch;
   logic [sdw_pkg::MAIN_W-1:0]                     main_data;
   logic [sdw_pkg::FINE_W-1:0]                     fine_data;
   logic                                           load;
   logic                                           hw_clr;
   logic                                           sw_clr;
   logic [sdw_pkg::NUM_CH-1:0]                     ch_clr;
   logic                                           coding;
   logic [sdw_pkg::NUM_CH-1:0][sdw_pkg::MAIN_W-1:0] main_dat;
   logic [sdw_pkg::NUM_CH-1:0][sdw_pkg::MAIN_W-1:0] main_out;
   logic [sdw_pkg::NUM_CH-1:0][sdw_pkg::FINE_W-1:0] fine_dat;
   logic [sdw_pkg::NUM_CH-1:0][sdw_pkg::FINE_W-1:0] fine_out;
   modport ctl (output wr_main, wr_fine, ch, main_data, fine_data,
                output load, hw_clr, sw_clr, ch_clr, coding,
                input main_dat, main_out, fine_dat, fine_out);
   modport bank (input wr_main, wr_fine, ch, main_data, fine_data,
                 input load, hw_clr, sw_clr, ch_clr, coding,
                 output main_dat, main_out, fine_dat, fine_out);
endinterface

// ### design/sdw_rx.sv
// Serial receiver: samples the link and delivers whole 16-bit words.
module sdw_rx (
   // Clock and reset.
   input  wire logic ref_clk,
   input  wire logic resetn,
   // Serial link.
   input  wire logic frame_sync_n,
   input  wire logic serial_shift_clock,
   input  wire logic serial_data_in,
   // Received words.
   sdw_word_if.src   wout
);
   logic [2:0]                   sck_q;
   logic [1:0]                   fs_q;
   logic [1:0]                   sd_q;
   sdw_pkg::sdw_rx_state_t       st_q;
   sdw_pkg::sdw_rx_state_t       st_d;
   logic [sdw_pkg::CNT_W-1:0]    cnt_q;
   logic [sdw_pkg::WORD_W-1:0]   sh_q;
   logic                         valid_q;

   wire fall  = sck_q[2] & ~sck_q[1];
   wire frame = ~fs_q[1];
   wire take  = (st_q == sdw_pkg::RX_SHIFT) & frame & fall;
   wire last  = take & (cnt_q == sdw_pkg::CNT_LAST);

   always_comb begin
      case (st_q)
         sdw_pkg::RX_IDLE:  st_d = frame ? sdw_pkg::RX_SHIFT : st_q;
         sdw_pkg::RX_SHIFT: st_d = !frame ? sdw_pkg::RX_IDLE :
                                   last ? sdw_pkg::RX_HOLD : st_q;
         sdw_pkg::RX_HOLD:  st_d = frame ? st_q : sdw_pkg::RX_IDLE;
         default:           st_d = sdw_pkg::RX_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         // The serial clock idles high, so no edge is seen after reset.
         sck_q   <= 3'h7;
         fs_q    <= 2'h3;
         sd_q    <= 2'h0;
         st_q    <= sdw_pkg::RX_IDLE;
         cnt_q   <= '0;
         sh_q    <= '0;
         valid_q <= 1'b0;
      end else begin
         sck_q   <= {sck_q[1:0], serial_shift_clock};
         fs_q    <= {fs_q[0], frame_sync_n};
         sd_q    <= {sd_q[0], serial_data_in};
         st_q    <= st_d;
         // A frame that ends early leaves the count at zero.
         cnt_q   <= (st_q != sdw_pkg::RX_SHIFT) ? '0 :
                    take ? cnt_q + 1'b1 : cnt_q;
         sh_q    <= take ? {sh_q[sdw_pkg::WORD_W-2:0], sd_q[1]} : sh_q;
         valid_q <= last;
      end
   end

   assign wout.valid = valid_q;
   assign wout.word  = sh_q;

   a_word_after_16: assert property (@(posedge ref_clk) disable iff (!resetn)
      valid_q |-> cnt_q == sdw_pkg::CNT_WORD)
      else $error("word delivered without sixteen clock edges");
endmodule // sdw_rx

// ### design/sdw_bank.sv
// Data and output registers of every channel, double buffered.
module sdw_bank (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic resetn,
   // Register bank port.
   sdw_bank_if.bank b
);
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < sdw_pkg::NUM_CH; i++) begin
         if (!resetn) begin
            b.main_dat[i] <= sdw_pkg::MAIN_CLR;
            b.main_out[i] <= sdw_pkg::MAIN_CLR;
            b.fine_dat[i] <= sdw_pkg::fine_zero(sdw_pkg::CODING_RST);
            b.fine_out[i] <= sdw_pkg::fine_zero(sdw_pkg::CODING_RST);
         end else if (b.hw_clr) begin
            b.main_dat[i] <= sdw_pkg::MAIN_CLR;
            b.main_out[i] <= sdw_pkg::MAIN_CLR;
            b.fine_dat[i] <= sdw_pkg::fine_zero(b.coding);
            b.fine_out[i] <= sdw_pkg::fine_zero(b.coding);
         end else begin
            if (b.sw_clr || (b.load && b.ch_clr[i]))
               b.main_dat[i] <= sdw_pkg::MAIN_CLR;
            else if (b.wr_main && b.ch == i)
               b.main_dat[i] <= b.main_data;
            if (b.sw_clr || (b.load && b.ch_clr[i]))
               b.main_out[i] <= sdw_pkg::MAIN_CLR;
            else if (b.load)
               b.main_out[i] <= b.main_dat[i];
            if (b.wr_fine && b.ch == i)
               b.fine_dat[i] <= b.fine_data;
            if (b.load)
               b.fine_out[i] <= b.fine_dat[i];
         end
      end
   end
endmodule // sdw_bank

// ### testbench/sdw_host.sv
// Host model that drives the serial link of the word loader.
module sdw_host (
   // Clock.
   input  wire logic ref_clk,
   // Serial link.
   output logic      frame_sync_n,
   output logic      serial_shift_clock,
   output logic      serial_data_in
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      frame_sync_n       = 1'b1;
      serial_shift_clock = 1'b1;
      serial_data_in     = 1'b0;
   end

   task automatic half_bit();
      repeat (4) @(negedge ref_clk);
   endtask

   // Shifts the top n bits of w, then closes the frame and idles.
   task automatic send_bits(input logic [15:0] w, input int n);
      @(negedge ref_clk);
      frame_sync_n = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         serial_data_in = w[i];
         half_bit();
         serial_shift_clock = 1'b0;
         half_bit();
         serial_shift_clock = 1'b1;
      end
      half_bit();
      frame_sync_n   = 1'b1;
      serial_data_in = ~serial_data_in;
      half_bit();
   endtask
endmodule // sdw_host

// ### testbench/serial_dac_word_loader_test.sv
// Self-checking testbench of the serial DAC word loader.
module serial_dac_word_loader_test;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  ref_clk, resetn, frame_sync_n;
   logic                  serial_shift_clock, serial_data_in;
   logic                  load_outputs_n, clear_request_n;
   logic [7:0][9:0]       main_code, quad_main;
   logic [7:0][7:0]       fine_code;
   logic [7:0][1:0]       reference_select;
   logic [7:0]            channel_active;
   logic                  reference_on, coding_select;
   logic [9:0]            em [8];
   logic [7:0]            ef [8];
   int                    errors, tests_run;
   int                    cycles = 0;

   sdw_top sdw_top_inst (.ref_clk(ref_clk), .resetn(resetn),
      .frame_sync_n(frame_sync_n), .serial_shift_clock(serial_shift_clock),
      .serial_data_in(serial_data_in), .load_outputs_n(load_outputs_n),
      .clear_request_n(clear_request_n), .main_code(main_code),
      .fine_code(fine_code), .reference_select(reference_select),
      .channel_active(channel_active), .reference_on(reference_on),
      .coding_select(coding_select));
   sdw_top #(.OCTAL_VARIANT(1'b0)) quad_sdw_top_inst (.ref_clk(ref_clk),
      .resetn(resetn), .frame_sync_n(frame_sync_n),
      .serial_shift_clock(serial_shift_clock),
      .serial_data_in(serial_data_in), .load_outputs_n(load_outputs_n),
      .clear_request_n(clear_request_n), .main_code(quad_main),
      .fine_code(), .reference_select(), .channel_active(),
      .reference_on(), .coding_select());
   sdw_host host_inst (.ref_clk(ref_clk), .frame_sync_n(frame_sync_n),
      .serial_shift_clock(serial_shift_clock),
      .serial_data_in(serial_data_in));

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic print_verdict();
      if (errors == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // A hang counts as a mismatch and ends the run.
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         print_verdict();
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic load();
      @(negedge ref_clk);
      load_outputs_n = 1'b0;
      repeat (2) @(negedge ref_clk);
      load_outputs_n = 1'b1;
      repeat (4) @(negedge ref_clk);
   endtask

   task automatic check_codes();
      for (int i = 0; i < 8; i++) begin
         chk(16'(main_code[i]), 16'(em[i]));
         chk(16'(fine_code[i]), 16'(ef[i]));
      end
   endtask

   initial begin
      resetn          = 1'b0;
      load_outputs_n  = 1'b1;
      clear_request_n = 1'b1;
      errors          = 0;
      tests_run       = 0;
      repeat (5) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk(16'(coding_select), 16'h0000);
      chk(16'(reference_on), 16'h0001);
      chk(16'(channel_active), 16'h00ff);
      // Main words with select low clear, fine words with it set.
      for (int i = 0; i < 8; i++) begin
         em[i] = 10'h2c0 | 10'(i);
         ef[i] = 8'ha0 | 8'(i);
         host_inst.send_bits({3'b001, 3'(i), em[i]}, 16);
         host_inst.send_bits({3'b111, 3'(i), ef[i], 2'b11}, 16);
      end
      chk(16'(main_code[7]), 16'h0000);
      load();
      check_codes();
      for (int i = 0; i < 4; i++) begin
         chk(16'(quad_main[i]), 16'(em[i + 4]));
      end
      // Reference codes 0..3 on channels 2..5, channel 3 idled.
      for (int i = 0; i < 4; i++) begin
         host_inst.send_bits({3'b010, 3'(i + 2), 2'(i), 3'h0,
                              (i != 1), 4'h0}, 16);
      end
      for (int i = 0; i < 8; i++) begin
         chk(16'(reference_select[i]),
             (i >= 2 && i < 6) ? 16'(i - 2) : 16'h0000);
      end
      chk(16'(channel_active), 16'h00f7);
      // Channel clear acts only once the load strobe follows.
      host_inst.send_bits({3'b010, 3'd1, 5'h00, 2'b11, 3'b000}, 16);
      chk(16'(main_code[1]), 16'(em[1]));
      load();
      em[1] = 10'h000;
      check_codes();
      host_inst.send_bits({3'b010, 3'd1, 5'h00, 2'b10, 3'b000}, 16);
      // System word with address bits set: coding, power, standby.
      host_inst.send_bits({6'h07, 3'h0, 4'ha, 3'b000}, 16);
      chk(16'(coding_select), 16'h0001);
      chk(16'(reference_on), 16'h0000);
      chk(16'(channel_active), 16'h0000);
      host_inst.send_bits({6'h00, 3'h0, 4'hd, 3'b000}, 16);
      for (int i = 0; i < 8; i++) em[i] = 10'h000;
      check_codes();
      chk(16'(channel_active), 16'h00f7);
      host_inst.send_bits({6'h00, 3'h0, 4'hc, 3'b000}, 16);
      // A cut frame must leave no trace in the next word.
      host_inst.send_bits({3'b001, 3'd0, 10'h3ff}, 8);
      em[0] = 10'h155;
      host_inst.send_bits({3'b001, 3'd0, em[0]}, 16);
      load();
      check_codes();
      // A strobe held low through a frame still moves the new word.
      load_outputs_n = 1'b0;
      em[2] = 10'h2aa;
      host_inst.send_bits({3'b001, 3'd2, em[2]}, 16);
      load_outputs_n = 1'b1;
      check_codes();
      // Hardware clear under offset binary coding.
      clear_request_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      for (int i = 0; i < 8; i++) begin
         em[i] = 10'h000;
         ef[i] = 8'h80;
      end
      check_codes();
      chk(16'(fine_code[6]), 16'h0080);
      chk(16'(main_code[6]), 16'h0000);
      // Two's complement under a held clear re-centres the fine codes.
      host_inst.send_bits({6'h00, 3'h0, 4'h4, 3'b000}, 16);
      for (int i = 0; i < 8; i++) ef[i] = 8'h00;
      check_codes();
      chk(16'(coding_select), 16'h0000);
      clear_request_n = 1'b1;
      print_verdict();
   end
endmodule // serial_dac_word_loader_test
